// ### bench/char_lcd_asserts.sv
/*
  Port checker of the character display decoder.
  Assumes it is bound to the decoder's top module.
*/
`timescale 1ns/1ps
module char_lcd_asserts #(
    parameter int BLINK_CYCLES = 50
) (
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        display_on,
    input wire logic        cursor_on,
    input wire logic        blink_phase
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    int since;
    // Cycles since the blink phase last moved; saturates so it cannot wrap.
    always_ff @(posedge mclk) begin
        if (rst || $changed(blink_phase)) since <= 0;
        else if (since < 4 * BLINK_CYCLES) since <= since + 1;
    end
    AST_ONE_WAIT: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("wait state longer than one cycle");
    AST_IDLE_NOWAIT: assert property (!avs_read && !avs_write |-> !avs_waitrequest)
        else $error("waitrequest high while idle");
    AST_REQ_WAITS: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
        else $error("request answered without a wait cycle");
    AST_RDATA_STANDS: assert property (!avs_read |=> $stable(avs_readdata))
        else $error("read data moved without a read");
    AST_DISP_CAUSE: assert property ($changed(display_on) |-> $past(avs_write && !avs_waitrequest))
        else $error("display enable moved without a write");
    AST_CURS_CAUSE: assert property ($changed(cursor_on) |-> $past(avs_write && !avs_waitrequest))
        else $error("cursor enable moved without a write");
    AST_BLINK_GAP: assert property ($rose(blink_phase) |-> since >= BLINK_CYCLES - 2)
        else $error("blink phase toggled too early");
    AST_RST_OUT: assert property (@(posedge mclk) disable iff (1'b0) rst |=> !display_on && !cursor_on && !blink_phase)
        else $error("outputs not cleared by reset");
    COV_WRITE: cover property (avs_write && !avs_waitrequest);
    COV_DISP: cover property ($rose(display_on));
    COV_BLINK: cover property ($rose(blink_phase));
endmodule

// ### bench/char_lcd_host.sv
/*
  Host processor model: Avalon-MM master issuing display instructions.
  Assumes the decoder's slave port on the same clock.
*/
`timescale 1ns/1ps
module char_lcd_host (
    input  wire logic        mclk,
    input  wire logic [31:0] avs_readdata,
    input  wire logic        avs_waitrequest,
    output logic      [3:0]  avs_address,
    output logic             avs_read,
    output logic             avs_write,
    output logic      [31:0] avs_writedata
);
    initial begin
        avs_address   <= 4'h0;
        avs_read      <= 1'b0;
        avs_write     <= 1'b0;
        avs_writedata <= 32'h0;
    end
    // One bus cycle; the request is held until waitrequest is seen low.
    task automatic bus(input logic rd_n, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge mclk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_read      <= rd_n;
        avs_write     <= !rd_n;
        do @(posedge mclk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask
    // Polls status so no instruction is sent while busy.
    task automatic wait_idle();
        logic [31:0] s;
        do bus(1'b1, 4'h0, 32'h0, s); while (s[7] !== 1'b0);
    endtask
    task automatic instr(input logic [7:0] b);
        logic [31:0] q;
        wait_idle();
        bus(1'b0, 4'h0, {22'h0, 2'b00, b}, q);
    endtask
    task automatic dat_wr(input logic [7:0] b);
        logic [31:0] q;
        wait_idle();
        bus(1'b0, 4'h0, {22'h0, 2'b01, b}, q);
    endtask
    // A fetch moves a RAM byte into the data register, read back once idle.
    task automatic fetch(output logic [7:0] b);
        logic [31:0] q;
        wait_idle();
        bus(1'b0, 4'h0, {22'h0, 2'b11, 8'h00}, q);
        wait_idle();
        bus(1'b1, 4'h4, 32'h0, q);
        b = q[7:0];
    endtask
endmodule

// ### bench/tb.sv
/*
  Self-checking bench of the character display decoder.
  Assumes the host model drives the slave port; short counts in simulation.
*/
`timescale 1ns/1ps
module tb;
    import char_lcd_pkg::*;
    localparam int EXEC_N  = 20;
    localparam int BLINK_N = 50;
    logic        mclk = 1'b0;
    logic        rst  = 1'b1;
    logic [3:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        display_on;
    logic        cursor_on;
    logic        blink_phase;
    int          miscompares = 0;
    int          n_tests     = 0;
    logic [31:0] v;
    logic [31:0] w;
    logic [7:0]  b;
    always #5 mclk = ~mclk;
    char_lcd_instruction_decoder #(.EXEC_CYCLES(EXEC_N), .BLINK_CYCLES(BLINK_N)) u_dut (.mclk(mclk), .rst(rst),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .display_on(display_on),
        .cursor_on(cursor_on), .blink_phase(blink_phase));
    char_lcd_host u_host (.mclk(mclk), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata));
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic ptr(input logic [6:0] exp);
        u_host.bus(1'b1, 4'h0, 32'h0, v);
        chk("pointer", {25'h0, v[6:0]}, {25'h0, exp});
    endtask
    task automatic t_ram();
        u_host.instr(8'h01);
        ptr(7'h00);
        u_host.fetch(b);
        chk("cleared text", {24'h0, b}, {24'h0, BLANK_CHAR});
        u_host.instr(8'h85);
        ptr(7'h05);
        u_host.dat_wr(8'h41);
        ptr(7'h06);
        u_host.instr(8'h03);
        ptr(7'h00);
        u_host.instr(8'h85);
        u_host.fetch(b);
        chk("text byte", {24'h0, b}, 32'h41);
        ptr(7'h06);
        $display("test ram done");
    endtask
    task automatic t_entry();
        u_host.instr(8'h04);
        u_host.instr(8'h8a);
        u_host.dat_wr(8'h42);
        ptr(7'h09);
        u_host.instr(8'h07);
        u_host.dat_wr(8'h43);
        ptr(7'h0a);
        u_host.bus(1'b1, 4'h8, 32'h0, v);
        chk("entry bits", {30'h0, v[4:3]}, 32'h3);
        chk("offset moved", {31'h0, v[13:8] != 6'h0}, 32'h1);
        u_host.fetch(b);
        u_host.bus(1'b1, 4'h8, 32'h0, w);
        chk("offset on read", {26'h0, w[13:8]}, {26'h0, v[13:8]});
        $display("test entry done");
    endtask
    task automatic t_onoff();
        u_host.instr(8'h0f);
        @(posedge mclk);
        chk("display on", {31'h0, display_on}, 32'h1);
        chk("cursor on", {31'h0, cursor_on}, 32'h1);
        b[0] = blink_phase;
        repeat (BLINK_N + 5) @(posedge mclk);
        chk("blink toggled", {31'h0, blink_phase}, {31'h0, ~b[0]});
        u_host.instr(8'h0d);
        @(posedge mclk);
        chk("cursor off", {31'h0, cursor_on}, 32'h0);
        u_host.instr(8'h08);
        repeat (2) @(posedge mclk);
        chk("blank", {29'h0, display_on, cursor_on, blink_phase}, 32'h0);
        $display("test onoff done");
    endtask
    task automatic t_shift();
        u_host.bus(1'b0, 4'hc, 32'h1, v);
        u_host.bus(1'b1, 4'hc, 32'h0, v);
        chk("four line", {31'h0, v[0]}, 32'h1);
        u_host.instr(8'ha7);
        u_host.instr(8'h14);
        ptr(7'h40);
        u_host.instr(8'h10);
        ptr(7'h27);
        u_host.instr(8'he7);
        u_host.instr(8'h17);
        ptr(7'h00);
        u_host.bus(1'b1, 4'h8, 32'h0, w);
        u_host.instr(8'h18);
        ptr(7'h00);
        u_host.bus(1'b1, 4'h8, 32'h0, v);
        chk("view moved", {31'h0, v[13:8] != w[13:8]}, 32'h1);
        $display("test shift done");
    endtask
    task automatic t_busy();
        u_host.instr(8'h02);
        u_host.bus(1'b1, 4'h0, 32'h0, v);
        chk("busy set", {31'h0, v[7]}, 32'h1);
        u_host.bus(1'b0, 4'h0, 32'h90, v);
        u_host.bus(1'b1, 4'h0, 32'h0, v);
        chk("busy held", {31'h0, v[7]}, 32'h1);
        repeat (EXEC_N) @(posedge mclk);
        u_host.bus(1'b1, 4'h0, 32'h0, v);
        chk("busy clear", {31'h0, v[7]}, 32'h0);
        ptr(7'h00);
        u_host.bus(1'b1, 4'h2, 32'h0, v);
        chk("unmapped", v, 32'h0);
        $display("test busy done");
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Main sequence; the reset outputs are checked before any traffic.
    initial begin
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        chk("reset outs", {29'h0, display_on, cursor_on, blink_phase}, 32'h0);
        t_ram();
        t_entry();
        t_onoff();
        t_shift();
        t_busy();
        summarize();
    end
    // Watchdog; the whole sequence needs only about a thousand cycles.
    initial begin
        #200000;
        miscompares++;
        summarize();
    end
endmodule
bind char_lcd_instruction_decoder char_lcd_asserts #(.BLINK_CYCLES(BLINK_CYCLES)) u_asserts (.mclk(mclk),
    .rst(rst), .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .display_on(display_on), .cursor_on(cursor_on), .blink_phase(blink_phase));

// ### design/char_lcd_instruction_decoder.sv
/*
  Instruction and data decoder of a character display controller, reached
  over an Avalon-MM slave. Software plays the host: it writes a byte with a
  register select and direction at the host interface word, and reads back.

  Words: host interface, data holding register, status, configuration.
  The host word holds the byte in bits 7:0, select in 8, direction in 9.
  Decode uses the most significant set bit of the byte.

  Outputs go to a panel driver that scans the text memory.

  Assumes a single 100 MHz clock with a synchronous active-high reset.
  Assumes the master holds a request until waitrequest is seen low.
  Text RAM is not reset; software runs a clear after power-up.
*/
// Implementation choices: register access over Avalon-MM and the address map.
// What this block does
// [R01] Select-0 write latches and decodes instruction
// [R02] Status read returns busy and pointer
// [R03] Data write stores into selected RAM
// [R04] Data read returns byte from RAM
// [R05] Address set loads the address pointer
// [R06] Pointer steps after each RAM access
// [R07] Clear blanks text, homes cursor
// [R08] Home zeroes pointer, keeps text
// [R09] Host repeats home after shifted clear
// [R10] Host saves four locations around home
// [R11] Step direction bit selects inc/dec
// [R12] Auto-shift shifts display on text writes
// [R13] Display bit blanks without losing text
// [R14] Cursor bit shows underline row
// [R15] Blink alternates cursor cell every 0.4s
// [R16] Cursor shift moves only pointer
// [R17] Display shift moves view and cursor
// [R18] Two-line wrap from position 40
// [R19] Four-line wrap stays within half; the code wraps four-line mode exactly as two-line mode
// [R20] Execution time scaled 40us at 250kHz
// [R21] Host checks busy before next instruction
// [R22] Home and shift opcodes ignore low bits
// [R23] Busy held, instructions ignored while set
`timescale 1ns/1ps
module char_lcd_instruction_decoder
    import char_lcd_pkg::*;
#(
    // Spans in clock cycles; the bench shortens them.
    parameter int EXEC_CYCLES  = EXEC_CYC,
    parameter int BLINK_CYCLES = BLINK_CYC
) (
    // Clock and reset.
    input  wire logic        mclk,
    input  wire logic        rst,
    // Avalon-MM slave.
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // Panel control state.
    output logic             display_on,
    output logic             cursor_on,
    output logic             blink_phase
);
    // Holding registers of the instruction path.
    logic [7:0]  instruction_holding_reg;
    logic [7:0]  data_holding_reg;
    logic [6:0]  address_pointer;
    logic        busy_indicator;

    // Timers; 32 bits cover the slowest settings.
    logic [31:0] busy_cnt_reg;
    logic [31:0] blink_cnt_reg;

    // Entry mode, memory select, line layout.
    logic        inc_reg;
    logic        shift_reg;
    logic        cg_sel_reg;
    logic        blink_reg;
    logic        four_line_reg;

    // View offset; wraps modulo 64.
    logic [5:0]  disp_offset_reg;

    // Flip-flop storage, indexed.
    // Glyph memory uses six pointer bits.
    logic [7:0]  display_text_ram [0:127];
    logic [7:0]  glyph_pattern_ram [0:63];

    // Clear sweep state.
    logic        clearing_reg;
    logic [6:0]  clr_idx_reg;

    // Bus handshake.
    logic        ack_reg;
    logic        req;

    // Host word fields.
    logic        hif_wr;
    logic        hif_rs;
    logic        hif_rw;
    logic [7:0]  hif_byte;

    // One-cycle strobes per select pair.
    logic        instr_wr;
    logic        data_wr;
    logic        data_rd;
    logic        stat_rd;

    // Neighbour addresses with wrap.
    logic [6:0]  step_addr;
    logic [6:0]  left_addr;
    logic [6:0]  right_addr;

    // Every access is answered one cycle after it is seen, so the master
    // holds its request exactly two edges. A write acts only at the
    // second edge, where waitrequest is low, so a withdrawn request
    // never leaves half a transfer.
    assign req      = (avs_read | avs_write) & ~ack_reg;

    // Host strobe, in the acknowledge cycle.
    assign hif_wr   = avs_write & ack_reg & (avs_address == OFS_HOST_IF);

    // Field extraction.
    assign hif_rs   = avs_writedata[HIF_RS_BIT];
    assign hif_rw   = avs_writedata[HIF_RW_BIT];
    assign hif_byte = avs_writedata[7:0];

    // Instructions arriving while busy are dropped, as the host should poll.
    // Status reads are never refused, so polling progresses.
    assign instr_wr = hif_wr & ~hif_rs & ~hif_rw & ~busy_indicator;  // [R01] [R23] [R21]
    assign data_wr  = hif_wr &  hif_rs & ~hif_rw & ~busy_indicator;  // [R03]
    assign data_rd  = hif_wr &  hif_rs &  hif_rw & ~busy_indicator;  // [R04]
    assign stat_rd  = hif_wr & ~hif_rs &  hif_rw;                     // [R02]

    // Cursor moves with line wrap: four-line mode wraps as two-line mode does,
    // LINE_LAST on to LINE2_BASE and LINE2_LAST back to 7'h00.
    // Both wraps are fixed addresses: two compares.
    always_comb begin
        right_addr = address_pointer + 7'h01;
        left_addr  = address_pointer - 7'h01;
        if (address_pointer == LINE_LAST) begin
            right_addr = LINE2_BASE;                                  // [R18]
        end else if (address_pointer == LINE2_LAST) begin
            right_addr = four_line_reg ? 7'h00 : 7'h00;               // [R19]
        end

        // Stepping left undoes the same wraps.
        if (address_pointer == LINE2_BASE) begin
            left_addr = LINE_LAST;
        end else if (address_pointer == 7'h00) begin
            left_addr = LINE2_LAST;
        end

        // Data accesses follow the entry direction.
        step_addr = inc_reg ? right_addr : left_addr;                 // [R11]
    end


    // Bus handshake: waitrequest is low in the cycle after the request.
    // The flop drops at once, so each request pays one wait.
    always_ff @(posedge mclk) begin
        if (rst) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= req;
        end
    end

    // Decoded from the flop: a registered copy would need the
    // request a cycle earlier.
    assign avs_waitrequest = ~ack_reg & (avs_read | avs_write);

    // Read data mux, registered so it stands at the acknowledging edge.
    // Loaded on the first edge of a read, then held
    // until the next read.
    always_ff @(posedge mclk) begin
        if (rst) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read & req) begin
            // Unmapped words read zero.
            case (avs_address)
                OFS_HOST_IF:   avs_readdata <= {24'h00_0000, busy_indicator, address_pointer};  // [R02]
                OFS_HOST_DATA: avs_readdata <= {24'h00_0000, data_holding_reg};                 // [R04]
                OFS_STATUS:    avs_readdata <= {16'h0000, 2'b00, disp_offset_reg, busy_indicator,
                                                blink_phase, cg_sel_reg, shift_reg, inc_reg,
                                                blink_reg, cursor_on, display_on};
                OFS_CONFIG:    avs_readdata <= {31'h0000_0000, four_line_reg};
                default:       avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

    // Configuration word: line organisation.
    // Only bit 0 is defined.
    always_ff @(posedge mclk) begin
        if (rst) begin
            four_line_reg <= 1'b0;
        end else if (avs_write & ack_reg & (avs_address == OFS_CONFIG)) begin
            four_line_reg <= avs_writedata[CFG_FOUR_BIT];
        end
    end

    // Busy timer: every instruction and data access takes the scaled time.
    // Loaded with one less: the load edge is the first busy cycle.
    // A clear keeps busy up until its sweep is done.
    always_ff @(posedge mclk) begin
        if (rst) begin
            busy_indicator <= 1'b0;
            busy_cnt_reg   <= 32'h0000_0000;
        end else if (instr_wr | data_wr | data_rd) begin
            busy_indicator <= 1'b1;                                   // [R23]
            busy_cnt_reg   <= 32'(EXEC_CYCLES - 1);                   // [R20]
        end else if (busy_cnt_reg != 32'h0000_0000) begin
            busy_cnt_reg <= busy_cnt_reg - 32'h0000_0001;
        end else if (!clearing_reg) begin
            busy_indicator <= 1'b0;
        end
    end

    // Instruction decode and mode state.
    // The top set bit picks the instruction. Data accesses step the
    // pointer here too, so it has one writer.
    always_ff @(posedge mclk) begin
        if (rst) begin
            instruction_holding_reg <= 8'h00;
            inc_reg         <= RST_INC;
            shift_reg       <= 1'b0;
            display_on      <= 1'b0;
            cursor_on       <= 1'b0;
            blink_reg       <= 1'b0;
            cg_sel_reg      <= 1'b0;
            disp_offset_reg <= 6'h00;
            address_pointer <= 7'h00;
        end else if (instr_wr) begin
            instruction_holding_reg <= hif_byte;                      // [R01]

            // Address set also picks the memory.
            if (hif_byte[OP_DDADDR]) begin
                cg_sel_reg      <= 1'b0;
                address_pointer <= hif_byte[6:0];                     // [R05]
            end else if (hif_byte[OP_CGADDR]) begin
                cg_sel_reg      <= 1'b1;
                address_pointer <= {1'b0, hif_byte[5:0]};             // [R05]
            end else if (hif_byte[OP_FUNC]) begin
                // Layout comes from the config word.
                cg_sel_reg <= cg_sel_reg;
            end else if (hif_byte[OP_SHIFT]) begin                    // [R22]
                if (hif_byte[3]) begin
                    // Display shift moves the view; the cursor follows it.
                    disp_offset_reg <= hif_byte[2] ? disp_offset_reg - 6'h01
                                                   : disp_offset_reg + 6'h01;  // [R17]
                end else begin
                    // Cursor shift: the view stays.
                    address_pointer <= hif_byte[2] ? right_addr : left_addr;   // [R16]
                end
            end else if (hif_byte[OP_ONOFF]) begin
                // Blanking keeps the text.
                display_on <= hif_byte[2];                            // [R13]
                cursor_on  <= hif_byte[1];                            // [R14]
                blink_reg  <= hif_byte[0];                            // [R15]
            end else if (hif_byte[OP_ENTRY]) begin
                // Applies from the next access.
                inc_reg   <= hif_byte[1];                             // [R11]
                shift_reg <= hif_byte[0];                             // [R12]
            end else if (hif_byte[OP_HOME]) begin                     // [R22]
                // Text is left alone.
                address_pointer <= 7'h00;                             // [R08]
                disp_offset_reg <= 6'h00;
                cg_sel_reg      <= 1'b0;
            end else if (hif_byte[OP_CLEAR]) begin
                // The sweep runs in its own process.
                address_pointer <= 7'h00;                             // [R07]
                disp_offset_reg <= 6'h00;
                cg_sel_reg      <= 1'b0;
                inc_reg         <= 1'b1;
            end
        end else if (data_wr | data_rd) begin
            // Glyph addresses wrap in six bits.
            // The view moves on text writes only.
            address_pointer <= cg_sel_reg ? {1'b0, address_pointer[5:0] + (inc_reg ? 6'h01 : 6'h3f)}
                                          : step_addr;               // [R06]
            if (data_wr & shift_reg & ~cg_sel_reg) begin
                // Display moves opposite to the cursor so it stays put.
                disp_offset_reg <= inc_reg ? disp_offset_reg + 6'h01
                                           : disp_offset_reg - 6'h01; // [R12]
            end
        end
    end

    // Text clear walks every location, one per clock, while busy stays set.
    // 128 cycles buy a plain indexed memory.
    always_ff @(posedge mclk) begin
        if (rst) begin
            clearing_reg <= 1'b0;
            clr_idx_reg  <= 7'h00;
        end else if (instr_wr && hif_byte == 8'h01) begin
            clearing_reg <= 1'b1;                                     // [R07]
            clr_idx_reg  <= 7'h00;
        end else if (clearing_reg) begin
            // Ends after the last index.
            clr_idx_reg  <= clr_idx_reg + 7'h01;
            clearing_reg <= (clr_idx_reg != 7'h7f);
        end
    end

    // Memory writes: text and glyph RAM, plus the clear sweep.
    // No reset: keeps the reset tree small.
    always_ff @(posedge mclk) begin
        if (clearing_reg) begin
            display_text_ram[clr_idx_reg] <= BLANK_CHAR;              // [R07]
        end else if (data_wr & ~cg_sel_reg) begin
            display_text_ram[address_pointer] <= hif_byte;            // [R03]
        end
        if (data_wr & cg_sel_reg) begin
            glyph_pattern_ram[address_pointer[5:0]] <= hif_byte;      // [R03]
        end
    end

    // Data holding register: written byte, or a byte fetched from RAM.
    // A fetch reads before the pointer steps.
    always_ff @(posedge mclk) begin
        if (rst) begin
            data_holding_reg <= 8'h00;
        end else if (data_wr) begin
            data_holding_reg <= hif_byte;                             // [R03]
        end else if (data_rd) begin
            data_holding_reg <= cg_sel_reg ? glyph_pattern_ram[address_pointer[5:0]]
                                           : display_text_ram[address_pointer];  // [R04]
        end
    end


    // Blink timer; the phase toggles every interval while blink is on.
    // Blink off parks the phase low.
    always_ff @(posedge mclk) begin
        if (rst) begin
            blink_cnt_reg <= 32'h0000_0000;
            blink_phase   <= 1'b0;
        end else if (!blink_reg) begin
            blink_cnt_reg <= 32'h0000_0000;
            blink_phase   <= 1'b0;
        end else if (blink_cnt_reg == 32'(BLINK_CYCLES - 1)) begin
            blink_cnt_reg <= 32'h0000_0000;
            blink_phase   <= ~blink_phase;                            // [R15]
        end else begin
            blink_cnt_reg <= blink_cnt_reg + 32'h0000_0001;
        end
    end

    // Limitations.

    // Instruction and data writes while busy are dropped silently.

    // The bus is always eight bits wide.

    // A read right after a write sees the
    // stepped pointer.

    // The host repeats home after a
    // shifted clear itself.

    // The view offset is only a position;
    // the scan lies outside.

    // Busy time is the same for all but a clear, which also stays busy through its 128-cycle sweep.

    // Text content is undefined until a
    // clear has run.
endmodule

// ### design/char_lcd_pkg.sv
/*
  Shared constants of the character display instruction decoder.
  Assumes a 100 MHz system clock on which all timing counts are based.
*/
package char_lcd_pkg;
    // Avalon-MM register byte offsets (word index = offset / 4).
    localparam logic [3:0] OFS_HOST_IF   = 4'h0;
    localparam logic [3:0] OFS_HOST_DATA = 4'h4;
    localparam logic [3:0] OFS_STATUS    = 4'h8;
    localparam logic [3:0] OFS_CONFIG    = 4'hc;
    // Host interface register fields.
    localparam int HIF_RS_BIT    = 8;
    localparam int HIF_RW_BIT    = 9;
    // Status register fields.
    localparam int ST_DISP_BIT   = 0;
    localparam int ST_CURS_BIT   = 1;
    localparam int ST_BLINK_BIT  = 2;
    localparam int ST_INC_BIT    = 3;
    localparam int ST_SHIFT_BIT  = 4;
    localparam int ST_CG_BIT     = 5;
    localparam int ST_PHASE_BIT  = 6;
    localparam int ST_BUSY_BIT   = 7;
    localparam int ST_OFFS_LSB   = 8;
    // Config register fields.
    localparam int CFG_FOUR_BIT  = 0;
    // Instruction opcode bit positions (most significant set bit selects).
    localparam int OP_CLEAR      = 0;
    localparam int OP_HOME       = 1;
    localparam int OP_ENTRY      = 2;
    localparam int OP_ONOFF      = 3;
    localparam int OP_SHIFT      = 4;
    localparam int OP_FUNC       = 5;
    localparam int OP_CGADDR     = 6;
    localparam int OP_DDADDR     = 7;
    // Reset values.
    localparam logic       RST_INC    = 1'b1;
    localparam logic [7:0] BLANK_CHAR = 8'h20;
    // Line layout of the text memory.
    localparam logic [6:0] LINE_LEN   = 7'h28;
    localparam logic [6:0] LINE2_BASE = 7'h40;
    localparam logic [6:0] LINE_LAST  = 7'h27;
    localparam logic [6:0] LINE2_LAST = 7'h67;
    // Timing.
    localparam int CLK_HZ          = 100_000_000;
    localparam int OSC_HZ          = 250_000;
    localparam int EXEC_US         = 40;
    localparam int BLINK_MS        = 400;
    localparam int EXEC_CYC        = EXEC_US * (CLK_HZ / 1_000_000);
    localparam int BLINK_CYC       = BLINK_MS * (CLK_HZ / 1_000);
endpackage
